// ### hdl/vbr_defines.svh
// Register offsets, field positions and reset values of the vibration readout block
`ifndef VBR_DEFINES_SVH
`define VBR_DEFINES_SVH

// Register port width
`define VBR_ADDR_W            7
`define VBR_DATA_W            16

// Register offsets
`define VBR_A_TEMPERATURE     7'h08
`define VBR_A_SUPPLY          7'h0A
`define VBR_A_SAMPLE_INDEX    7'h10
`define VBR_A_RECORD_SELECT   7'h12
`define VBR_A_X_READOUT       7'h14
`define VBR_A_Y_READOUT       7'h16
`define VBR_A_Z_READOUT       7'h18
`define VBR_A_GLOBAL_COMMAND  7'h3E
`define VBR_A_X_MAGNITUDE     7'h46
`define VBR_A_Y_MAGNITUDE     7'h48
`define VBR_A_Z_MAGNITUDE     7'h4A
`define VBR_A_TIME_LOW        7'h4C
`define VBR_A_TIME_HIGH       7'h4E
`define VBR_A_HEADER_A        7'h6E
`define VBR_A_X_BIN           7'h70
`define VBR_A_Y_BIN           7'h72
`define VBR_A_Z_BIN           7'h74
`define VBR_A_HEADER_B        7'h76

// Field layouts
`define VBR_CMD_RETRIEVE_BIT  13
`define VBR_INDEX_W           9
`define VBR_RECORD_W          4
`define VBR_BIN_W             8

// Last valid buffer index per mode
`define VBR_LAST_FFT          9'h0FF
`define VBR_LAST_TIME         9'h1FF

// Reset values
`define VBR_AXIS_RESET        16'h8000
`define VBR_ZERO16            16'h0000

`endif

// ### hdl/vbr_pkg.sv
// Types shared by the vibration readout block
`default_nettype none
`include "vbr_defines.svh"

package vbr_pkg;

  // Readout sequencer, one-hot
  typedef enum logic [2:0] {
    VBR_IDLE  = 3'h1,
    VBR_FETCH = 3'h2,
    VBR_LOAD  = 3'h4
  } vbr_state_t;

  // State of the readout block, apart from the record buffer and mem_q
  typedef struct packed {
    vbr_state_t                        st;
    logic [`VBR_INDEX_W-1:0]           idx;
    logic [`VBR_INDEX_W-1:0]           wr_idx;
    logic [`VBR_RECORD_W-1:0]          rec;
    logic [15:0]                       x_out;
    logic [15:0]                       y_out;
    logic [15:0]                       z_out;
    logic [15:0]                       peak_x;
    logic [15:0]                       peak_y;
    logic [15:0]                       peak_z;
    logic [`VBR_BIN_W-1:0]             bin_x;
    logic [`VBR_BIN_W-1:0]             bin_y;
    logic [`VBR_BIN_W-1:0]             bin_z;
    logic [15:0]                       time_low;
    logic [15:0]                       time_high;
    logic [15:0]                       info_a;
    logic [15:0]                       info_b;
    logic [15:0]                       temp;
    logic [15:0]                       supply;
    logic [15:0]                       rdata;
    logic                              rvalid;
    logic                              retrieve;
    logic [`VBR_RECORD_W-1:0]          retrieve_rec;
  } vbr_state_s_t;

endpackage : vbr_pkg

`default_nettype wire

// ### hdl/vbr_fifo.sv
// Parameterised FIFO between the sample source and the record buffer
`timescale 1ns/10ps
`default_nettype none

module vbr_fifo #(
  parameter int WIDTH = 49,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Filling side
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          full;
    logic          empty;
  } vbr_fifo_state_t;

  vbr_fifo_state_t  s;
  vbr_fifo_state_t  next_s;
  logic [WIDTH-1:0] store [DEPTH];
  logic             push;
  logic             pop;

  // Flags come from registers so the source sees a clean ready
  assign in_ready  = ~s.full;
  assign out_valid = ~s.empty;
  assign out_data  = store[s.rp];
  assign push      = in_valid & ~s.full;
  assign pop       = ~s.empty & out_ready;

  // Pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.full  = (next_s.cnt == (AW+1)'(DEPTH));
    next_s.empty = (next_s.cnt == '0);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      store[s.wp] <= in_data;
    end
  end

  no_overflow_a: assert property (@(posedge clock) disable iff (!reset_n)
    s.full |=> (s.cnt != '0))
    else $error("fifo lost its contents while full");

endmodule : vbr_fifo

`default_nettype wire

// ### hdl/vbr_readout.sv
// Vibration buffer readout: record buffer, index pointer, record header registers
//
// Summary of operation
// - Each axis has a read-only 16-bit worst-case alarm peak magnitude register.
// - Each axis has a read-only worst-case bin register, bin in low byte.
// - Time capture records hold 512 samples per axis.
// - FFT records hold a 256-point result per axis.
// - Record completion loads sample zero into axis registers and clears the index.
// - The index pointer selects which sample loads, also after a host write.
// - Index is 9 bits: 0..255 in FFT mode, 0..511 in time mode.
// - Every axis register read steps the index, wrapping to zero at the mode's end, and loads the next set.
// - FFT records live in external flash and can be fetched later.
// - Host writes record number, sets command bit 13; device loads that record.
// - Record select is read/write, resets to zero, field in low four bits.
// - Axis registers return data unchanged per mode and reset to 0x8000.
// - Output scaling follows range and recording mode, fixed by the source.
// - FFT code step at 5 g range is 5 g over 65536.
// - Time mode samples are 16-bit twos complement words.
// - Header registers update on every record and on record retrieval.
`timescale 1ns/10ps
`default_nettype none
`include "vbr_defines.svh"

module vbr_readout #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  // Register port
  input  wire logic [`VBR_ADDR_W-1:0]   reg_addr,
  input  wire logic [`VBR_DATA_W-1:0]   reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output var  logic [`VBR_DATA_W-1:0]   reg_rdata,
  output var  logic                     reg_rvalid,
  // Sample stream from capture engine or flash, {x, y, z}
  input  wire logic                     smp_valid,
  output var  logic                     smp_ready,
  input  wire logic [47:0]              smp_data,
  input  wire logic                     smp_last,
  // Record header values, stable while a record streams in
  input  wire logic [15:0]              hdr_peak_x,
  input  wire logic [15:0]              hdr_peak_y,
  input  wire logic [15:0]              hdr_peak_z,
  input  wire logic [`VBR_BIN_W-1:0]    hdr_bin_x,
  input  wire logic [`VBR_BIN_W-1:0]    hdr_bin_y,
  input  wire logic [`VBR_BIN_W-1:0]    hdr_bin_z,
  input  wire logic [15:0]              hdr_time_low,
  input  wire logic [15:0]              hdr_time_high,
  input  wire logic [15:0]              hdr_info_a,
  input  wire logic [15:0]              hdr_info_b,
  input  wire logic [15:0]              hdr_temp,
  input  wire logic [15:0]              hdr_supply,
  // Recording mode
  input  wire logic                     fft_mode,
  // Flash retrieve request
  output var  logic                     retrieve_req,
  output var  logic [`VBR_RECORD_W-1:0] retrieve_record
);

  localparam int NWORDS = 1 << `VBR_INDEX_W;

  vbr_pkg::vbr_state_s_t s;
  vbr_pkg::vbr_state_s_t next_s;

  logic [47:0]           buf_mem [NWORDS];
  logic [47:0]           mem_q;
  logic                  f_valid;
  logic                  f_ready;
  logic [48:0]           f_data;
  logic                  pop;
  logic                  pop_last;
  logic                  axis_rd;
  logic                  index_wr;
  logic                  trigger;

  // Last valid index for the active mode
  function automatic logic [`VBR_INDEX_W-1:0] last_index(input logic fft);
    last_index = fft ? `VBR_LAST_FFT : `VBR_LAST_TIME;
  endfunction : last_index

  // Any of the three axis readout registers
  function automatic logic is_axis(input logic [`VBR_ADDR_W-1:0] a);
    is_axis = (a == `VBR_A_X_READOUT) || (a == `VBR_A_Y_READOUT) ||
              (a == `VBR_A_Z_READOUT);
  endfunction : is_axis

  // Incoming words queue here while the readout owns the buffer port
  vbr_fifo #(
    .WIDTH (49),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   ({smp_last, smp_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Buffer port arbitration: host actions win, the FIFO drains when idle
  assign axis_rd  = reg_read & is_axis(reg_addr);
  assign index_wr = reg_write & (reg_addr == `VBR_A_SAMPLE_INDEX);
  assign trigger  = axis_rd | index_wr;
  assign f_ready  = (s.st == vbr_pkg::VBR_IDLE) & ~trigger;
  assign pop      = f_valid & f_ready;
  assign pop_last = pop & f_data[48];

  assign reg_rdata       = s.rdata;
  assign reg_rvalid      = s.rvalid;
  assign retrieve_req    = s.retrieve;
  assign retrieve_record = s.retrieve_rec;

  // Next state
  always_comb begin
    next_s          = s;
    next_s.rvalid   = 1'b0;
    next_s.retrieve = 1'b0;

    // Fetch takes one cycle of buffer latency, then load all three axes
    case (s.st)
      vbr_pkg::VBR_IDLE: begin
        next_s.st = vbr_pkg::VBR_IDLE;
      end
      vbr_pkg::VBR_FETCH: begin
        next_s.st = vbr_pkg::VBR_LOAD;
      end
      vbr_pkg::VBR_LOAD: begin
        next_s.st    = vbr_pkg::VBR_IDLE;
        next_s.x_out = mem_q[47:32];
        next_s.y_out = mem_q[31:16];
        next_s.z_out = mem_q[15:0];
      end
      default: begin
        next_s.st = vbr_pkg::VBR_IDLE;
      end
    endcase

    // Fill the record buffer; the source scales and formats each word
    if (pop) begin
      next_s.wr_idx = (s.wr_idx == last_index(fft_mode)) ? '0 : s.wr_idx + 1'b1;
    end

    // Record complete: header update, then sample zero into the axes
    if (pop_last) begin
      next_s.wr_idx    = '0;
      next_s.idx       = '0;
      next_s.st        = vbr_pkg::VBR_FETCH;
      next_s.peak_x    = hdr_peak_x;
      next_s.peak_y    = hdr_peak_y;
      next_s.peak_z    = hdr_peak_z;
      next_s.bin_x     = hdr_bin_x;
      next_s.bin_y     = hdr_bin_y;
      next_s.bin_z     = hdr_bin_z;
      next_s.time_low  = hdr_time_low;
      next_s.time_high = hdr_time_high;
      next_s.info_a    = hdr_info_a;
      next_s.info_b    = hdr_info_b;
      next_s.temp      = hdr_temp;
      next_s.supply    = hdr_supply;
    end

    // Register reads answer with the value held before any side effect
    if (reg_read) begin
      next_s.rvalid = 1'b1;
      case (reg_addr)
        `VBR_A_TEMPERATURE:   next_s.rdata = s.temp;
        `VBR_A_SUPPLY:        next_s.rdata = s.supply;
        `VBR_A_SAMPLE_INDEX:  next_s.rdata = {7'h00, s.idx};
        `VBR_A_RECORD_SELECT: next_s.rdata = {12'h000, s.rec};
        `VBR_A_X_READOUT:     next_s.rdata = s.x_out;
        `VBR_A_Y_READOUT:     next_s.rdata = s.y_out;
        `VBR_A_Z_READOUT:     next_s.rdata = s.z_out;
        `VBR_A_X_MAGNITUDE:   next_s.rdata = s.peak_x;
        `VBR_A_Y_MAGNITUDE:   next_s.rdata = s.peak_y;
        `VBR_A_Z_MAGNITUDE:   next_s.rdata = s.peak_z;
        `VBR_A_TIME_LOW:      next_s.rdata = s.time_low;
        `VBR_A_TIME_HIGH:     next_s.rdata = s.time_high;
        `VBR_A_HEADER_A:      next_s.rdata = s.info_a;
        `VBR_A_X_BIN:         next_s.rdata = {8'h00, s.bin_x};
        `VBR_A_Y_BIN:         next_s.rdata = {8'h00, s.bin_y};
        `VBR_A_Z_BIN:         next_s.rdata = {8'h00, s.bin_z};
        `VBR_A_HEADER_B:      next_s.rdata = s.info_b;
        default:              next_s.rdata = `VBR_ZERO16;
      endcase
    end

    // Axis read steps the pointer, wrapping at the mode's end
    if (axis_rd) begin
      next_s.idx = (s.idx >= last_index(fft_mode)) ? '0 : s.idx + 1'b1;
      next_s.st  = vbr_pkg::VBR_FETCH;
    end

    // Only index, record select and command are writable; others drop
    if (reg_write) begin
      case (reg_addr)
        `VBR_A_SAMPLE_INDEX: begin
          // Out-of-range index would address stale words, so it is forced to zero
          next_s.idx = (reg_wdata[`VBR_INDEX_W-1:0] > last_index(fft_mode)) ?
                       '0 : reg_wdata[`VBR_INDEX_W-1:0];
          next_s.st  = vbr_pkg::VBR_FETCH;
        end
        `VBR_A_RECORD_SELECT: begin
          next_s.rec = reg_wdata[`VBR_RECORD_W-1:0];
        end
        `VBR_A_GLOBAL_COMMAND: begin
          // Flash streams the record back through the sample port
          if (reg_wdata[`VBR_CMD_RETRIEVE_BIT]) begin
            next_s.retrieve     = 1'b1;
            next_s.retrieve_rec = s.rec;
          end
        end
        default: begin
          next_s.rec = s.rec;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s              <= '0;
      s.st           <= vbr_pkg::VBR_IDLE;
      s.x_out        <= `VBR_AXIS_RESET;
      s.y_out        <= `VBR_AXIS_RESET;
      s.z_out        <= `VBR_AXIS_RESET;
      s.temp         <= `VBR_AXIS_RESET;
      s.supply       <= `VBR_AXIS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Record buffer: single port, registered read, write only when idle
  always_ff @(posedge clock) begin
    if (pop) begin
      buf_mem[s.wr_idx] <= f_data[47:0];
    end
    if (s.st == vbr_pkg::VBR_FETCH) begin
      mem_q <= buf_mem[s.idx];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Record end: pointer back to zero and a reload of sample zero
  last_clears_idx_a: assert property (
    pop_last && !trigger |=> s.idx == '0 && s.st == vbr_pkg::VBR_FETCH)
    else $error("record end did not clear the index");

  // Case equality: a never-written buffer word must still pass through unchanged
  fetch_loads_axes_a: assert property (
    s.st == vbr_pkg::VBR_FETCH && !trigger && !pop_last
    |=> s.st == vbr_pkg::VBR_LOAD ##1 s.x_out === $past(mem_q[47:32]))
    else $error("fetched sample did not reach the axis register");

  read_steps_idx_a: assert property (
    axis_rd && !reg_write && s.idx < last_index(fft_mode)
    |=> s.idx == $past(s.idx) + 9'h001)
    else $error("axis read did not advance the index");

  index_wraps_a: assert property (
    axis_rd && !reg_write && s.idx >= last_index(fft_mode) |=> s.idx == '0)
    else $error("index did not wrap at the mode limit");

  // Host index writes: in range taken as is, beyond the mode limit parked at zero
  index_write_a: assert property (
    index_wr && reg_wdata[`VBR_INDEX_W-1:0] <= last_index(fft_mode)
    |=> s.idx == $past(reg_wdata[`VBR_INDEX_W-1:0]) && s.st == vbr_pkg::VBR_FETCH)
    else $error("index write not taken");

  index_limit_a: assert property (
    index_wr && reg_wdata[`VBR_INDEX_W-1:0] > last_index(fft_mode) |=> s.idx == '0)
    else $error("out-of-range index write not parked at zero");

  index_read_a: assert property (
    reg_read && reg_addr == `VBR_A_SAMPLE_INDEX |=> reg_rdata == {7'h00, $past(s.idx)})
    else $error("index readback wrong");

  record_sel_a: assert property (
    reg_write && reg_addr == `VBR_A_RECORD_SELECT
    |=> s.rec == $past(reg_wdata[`VBR_RECORD_W-1:0]))
    else $error("record select not stored");

  retrieve_cmd_a: assert property (
    reg_write && reg_addr == `VBR_A_GLOBAL_COMMAND && reg_wdata[`VBR_CMD_RETRIEVE_BIT]
    |=> retrieve_req && retrieve_record == $past(s.rec) ##1 !retrieve_req)
    else $error("retrieve request wrong");

  // A request may only follow a command write, so a stuck pulse shows here
  retrieve_only_a: assert property (
    !(reg_write && reg_addr == `VBR_A_GLOBAL_COMMAND) |=> !retrieve_req)
    else $error("retrieve request without a command");

  header_load_a: assert property (
    pop_last |=> s.peak_x == $past(hdr_peak_x) && s.bin_z == $past(hdr_bin_z))
    else $error("header not loaded at record end");

  ro_write_a: assert property (
    reg_write && !pop_last && reg_addr == `VBR_A_X_MAGNITUDE
    |=> s.peak_x == $past(s.peak_x))
    else $error("write altered a read-only register");

  // Outside a reload the axis registers ignore host writes
  axis_ro_a: assert property (
    reg_write && reg_addr == `VBR_A_X_READOUT && s.st != vbr_pkg::VBR_LOAD
    |=> s.x_out == $past(s.x_out))
    else $error("write altered an axis register");

  bin_upper_a: assert property (
    reg_read && reg_addr == `VBR_A_Y_BIN
    |=> reg_rvalid && reg_rdata[15:8] == 8'h00)
    else $error("bin register upper byte not zero");

  axis_answer_a: assert property (
    reg_read && reg_addr == `VBR_A_Z_READOUT
    |=> reg_rdata == $past(s.z_out))
    else $error("axis read returned wrong word");

  // Every read gets exactly one answer pulse, one cycle later
  read_answer_a: assert property (
    reg_read |=> reg_rvalid)
    else $error("read got no answer pulse");

  no_stray_answer_a: assert property (
    !reg_read |=> !reg_rvalid)
    else $error("answer pulse without a read");

  // Main scenarios: record end, wrap, retrieve, back-pressure
  record_end_c: cover property (pop_last ##2 s.st == vbr_pkg::VBR_LOAD);
  wrap_c: cover property (axis_rd && s.idx == `VBR_LAST_FFT && fft_mode);
  retrieve_c: cover property (retrieve_req);
  fifo_full_c: cover property (!smp_ready);
  stalled_read_c: cover property (axis_rd && f_valid && !smp_ready);

endmodule : vbr_readout

`default_nettype wire

// ### dv/vbr_src_model.sv
// Sample source model standing in for the capture engine and the record flash
`timescale 1ns/10ps
`default_nettype none

module vbr_src_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Requests from the bench and from the readout block
  input  wire logic        start,
  input  wire logic [8:0]  last_pos,
  input  wire logic        retrieve_req,
  input  wire logic [3:0]  retrieve_record,
  // Sample stream
  output var  logic        smp_valid,
  input  wire logic        smp_ready,
  output var  logic [47:0] smp_data,
  output var  logic        smp_last
);
  logic       busy;
  logic       tog;
  logic [8:0] pos;
  logic [3:0] rec;

  // One record per request; a word stays put until the readout side takes it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      tog  <= 1'b0;
      pos  <= 9'h000;
      rec  <= 4'h0;
    end else begin
      tog <= ~tog;
      if (!busy && (start || retrieve_req)) begin
        busy <= 1'b1;
        pos  <= 9'h000;
        rec  <= retrieve_req ? retrieve_record : 4'h0;
      end else if (busy && smp_ready) begin
        pos  <= pos + 9'h001;
        busy <= (pos != last_pos);
      end
    end
  end

  // Idle data lines toggle every cycle so a stale word can never pass as valid
  assign smp_valid = busy;
  assign smp_last  = busy && (pos == last_pos);
  assign smp_data  = busy ? {rec, 3'h1, pos, rec, 3'h2, pos, rec, 3'h4, pos}
                          : {24{tog, ~tog}};
endmodule : vbr_src_model

`default_nettype wire

// ### dv/vbr_readout_bench.sv
// Self-checking bench of the vibration readout block
`timescale 1ns/10ps
`default_nettype none

module vbr_readout_bench;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        smp_valid;
  logic        smp_ready;
  logic        smp_last;
  logic [47:0] smp_data;
  logic        fft_mode = 1'b1;
  logic        retrieve_req;
  logic [3:0]  retrieve_record;
  logic        start = 1'b0;
  logic [8:0]  last_pos = 9'h0FF;
  logic [15:0] hb = 16'h0000;
  logic [15:0] rd;
  logic [3:0]  req_rec = 4'h0;
  int          req_seen = 0;
  int          fail_count = 0;
  int          checks = 0;
  localparam logic [6:0] HA [12] = '{7'h46, 7'h48, 7'h4A, 7'h70, 7'h72, 7'h74,
                                     7'h4C, 7'h4E, 7'h6E, 7'h76, 7'h08, 7'h0A};

  // 50 MHz clock
  always #10 clock = ~clock;

  vbr_readout i_dut (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_data(smp_data), .smp_last(smp_last), .hdr_peak_x(hb),
    .hdr_peak_y(hb + 16'h0001), .hdr_peak_z(hb + 16'h0002),
    .hdr_bin_x(hb[7:0] + 8'h03), .hdr_bin_y(hb[7:0] + 8'h04),
    .hdr_bin_z(hb[7:0] + 8'h05), .hdr_time_low(hb + 16'h0006),
    .hdr_time_high(hb + 16'h0007), .hdr_info_a(hb + 16'h0008),
    .hdr_info_b(hb + 16'h0009), .hdr_temp(hb + 16'h000A),
    .hdr_supply(hb + 16'h000B), .fft_mode(fft_mode),
    .retrieve_req(retrieve_req), .retrieve_record(retrieve_record));

  vbr_src_model i_src (
    .clock(clock), .reset_n(reset_n), .start(start), .last_pos(last_pos),
    .retrieve_req(retrieve_req), .retrieve_record(retrieve_record),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
    .smp_last(smp_last));

  // Count retrieve pulses so a stuck-high request shows up as more than one
  always @(posedge clock) begin
    if (retrieve_req === 1'b1) begin
      req_seen++;
      req_rec = retrieve_record;
    end
  end

  // Expected sample word of one axis, as the source model builds it
  function automatic logic [15:0] sw(input int ax, input logic [3:0] r, input logic [8:0] p);
    return {r, 3'(1 << ax), p};
  endfunction : sw

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Writes and reads keep three idle cycles so each reload lands first
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    repeat (3) @(negedge clock);
  endtask : wr

  task automatic rdr(input logic [6:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    rd = reg_rdata;
    @(negedge clock);
    chk({15'h0000, reg_rvalid}, 16'h0000);
    repeat (2) @(negedge clock);
  endtask : rdr

  task automatic rc(input logic [6:0] a, input logic [15:0] exp);
    rdr(a);
    chk(rd, exp);
  endtask : rc

  // Bounded wait for the source to finish and the buffer to drain
  task automatic wait_rec();
    int n;
    n = 0;
    repeat (2) @(negedge clock);
    while (smp_valid === 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    chk(16'(n < 2000), 16'h0001);
    repeat (20) @(negedge clock);
  endtask : wait_rec

  task automatic stream(input logic [8:0] last);
    last_pos = last;
    @(negedge clock);
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    wait_rec();
  endtask : stream

  task automatic hdr_chk(input logic [15:0] b);
    for (int k = 0; k < 12; k++) begin
      rc(HA[k], (k > 2 && k < 6) ? {8'h00, b[7:0] + 8'(k)} : b + 16'(k));
    end
  endtask : hdr_chk

  task automatic t_reset();
    for (int k = 0; k < 12; k++) begin
      rc(HA[k], (k > 9) ? 16'h8000 : 16'h0000);
    end
    rc(7'h10, 16'h0000);
    rc(7'h12, 16'h0000);
    rc(7'h20, 16'h0000);
    rc(7'h14, 16'h8000);
    rc(7'h10, 16'h0001);
    wr(7'h46, 16'hFFFF);
    rc(7'h46, 16'h0000);
  endtask : t_reset

  task automatic t_fft();
    fft_mode = 1'b1;
    hb = 16'hC3F0;
    stream(9'h0FF);
    rc(7'h10, 16'h0000);
    rc(7'h14, sw(0, 4'h0, 9'h000));
    rc(7'h16, sw(1, 4'h0, 9'h001));
    rc(7'h18, sw(2, 4'h0, 9'h002));
    hdr_chk(hb);
    wr(7'h10, 16'h009F);
    rc(7'h14, sw(0, 4'h0, 9'h09F));
    wr(7'h10, 16'h0100);
    rc(7'h10, 16'h0000);
    wr(7'h14, 16'h1234);
    rc(7'h14, sw(0, 4'h0, 9'h000));
    for (int i = 1; i < 256; i++) begin
      rc(7'h14, sw(0, 4'h0, 9'(i)));
    end
    rc(7'h14, sw(0, 4'h0, 9'h000));
  endtask : t_fft

  task automatic t_time();
    fft_mode = 1'b0;
    hb = 16'h5A0C;
    stream(9'h1FF);
    rc(7'h46, hb);
    wr(7'h10, 16'h01FF);
    rc(7'h14, sw(0, 4'h0, 9'h1FF));
    rc(7'h10, 16'h0000);
    wr(7'h10, 16'h0100);
    rc(7'h18, sw(2, 4'h0, 9'h100));
  endtask : t_time

  task automatic t_retrieve();
    fft_mode = 1'b1;
    last_pos = 9'h0FF;
    wr(7'h12, 16'hFFF5);
    rc(7'h12, 16'h0005);
    wr(7'h12, 16'h000A);
    rc(7'h12, 16'h000A);
    hb = 16'h0F81;
    req_seen = 0;
    wr(7'h3E, 16'hDFFF);
    wr(7'h3E, 16'h2000);
    chk(16'(req_seen), 16'h0001);
    chk({12'h000, req_rec}, 16'h000A);
    wait_rec();
    hdr_chk(hb);
    rc(7'h14, sw(0, 4'hA, 9'h000));
  endtask : t_retrieve

  // Reads every third cycle keep the buffer port busy until the queue fills
  task automatic t_stall();
    int lo;
    lo = 0;
    fft_mode = 1'b1;
    last_pos = 9'h0FF;
    @(negedge clock);
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    for (int i = 0; i < 12; i++) begin
      reg_addr = 7'h16;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      if (smp_ready === 1'b0) begin
        lo++;
      end
      repeat (2) @(negedge clock);
    end
    chk(16'(lo > 0), 16'h0001);
    wait_rec();
    rc(7'h10, 16'h0000);
    rc(7'h14, sw(0, 4'h0, 9'h000));
    wr(7'h10, 16'h00FF);
    rc(7'h14, sw(0, 4'h0, 9'h0FF));
  endtask : t_stall

  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: two reset cycles, then the scenarios in turn
  initial begin
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_fft();
    t_time();
    t_retrieve();
    t_stall();
    print_verdict();
  end

  // Watchdog: the scenarios need about 3000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    print_verdict();
  end
endmodule : vbr_readout_bench

`default_nettype wire
